// ===== logic/icc_clock.v
// I2C calendar clock: slave port, BCD counters, snapshot buffers, control and flag registers
//
// Overview of operation
// - Below power-fail trip, refuse bus access; allow again after recovery delay.
// - Access opens with START and identification byte; bytes continue until STOP.
// - Time registers at 00h-06h, control at 07h, charger and flag at 08h-09h.
// - Multibyte pointer moves from 07h back to 00h, never to 08h.
// - 08h reached only by direct load, 09h also by stepping from 08h; after 09h pointer goes to 00h.
// - START, STOP and pointer rollover to 00h copy time into read buffers.
// - Time and calendar are packed BCD within their documented ranges.
// - Weekday advances at midnight and cycles 01 to 07.
// - Seconds bit 7 halts the oscillator; it powers up cleared.
// - With century enable set, century flag inverts on year 99 to 00.
// - Writing seconds resets the divider chain, restarting the current second.
// - Written bytes commit when the device drives the acknowledge.
// - Power-on time is 00:00:00 01/01/00 with weekday 01.
// - With test mode off, test output follows level bit, which powers up set.
// - With test mode on, test output toggles at 512Hz; mode powers up off.
// - Control bit 5 is calibration direction, powering up cleared.
// - Control bits 4:0 hold trim magnitude 0-31, powering up zero.
// - Charger key bits 7:4 decide whether the charger path is enabled.
// - Bits without a given power-up value may start anywhere.
// - Date rolls after each month's last day, leap Februaries included.
// - Charger enabled only with key 1010; disabled after power-up.
// - Diode code 01 or 10 and nonzero resistor code needed, else disabled.
// - Halt flag sets on run-to-stop; write 0 clears, 1 keeps; low bits read 0.
`include "icc_regs.vh"
module icc_clock #(
   parameter SEC_CYC = `ICC_SEC_CYC,
   parameter REC_CYC = `ICC_REC_CYC
) (
   input  wire       SYS_CLK,
   input  wire       RESETN,
   input  wire       SCL_IN,
   input  wire       SDA_IN,
   output reg        SDA_OUT,
   output reg        SDA_OE,
   input  wire       SUPPLY_OK,
   input  wire       OSC_RUNNING,
   output reg        TEST_OUT,
   output reg        TEST_OE,
   output reg        CHARGER_EN,
   output reg  [1:0] CHARGER_DIODE,
   output reg  [1:0] CHARGER_RES
);

   // State codes of the slave engine
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_RX   = 4'b0010;
   localparam [3:0] ST_ACK  = 4'b0100;
   localparam [3:0] ST_TX   = 4'b1000;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // no range check
   // BCD increment with wrap to a low value at a top value
   function [7:0] bcd_inc;
      input [7:0] v;
      input [7:0] top;
      input [7:0] low;
      begin
         if (v == top) begin
            bcd_inc = low;
         end else if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
         end
      end
   endfunction

   // Last day of a month, in BCD
   function [7:0] month_last;
      input [7:0] mon;
      input [7:0] yr;
      begin
         case (mon)
            8'h02: month_last = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                                       : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                                          yr[3:0] == 4'h8)) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
            default: month_last = 8'h31;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers, two flops each

   reg [3:0] sync1_ff;
   reg [3:0] sync2_ff;
   reg [1:0] prev_ff;
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         sync1_ff <= 4'hf;
         sync2_ff <= 4'hf;
         prev_ff  <= 2'h3;
      end else begin
         sync1_ff <= {OSC_RUNNING, SUPPLY_OK, SDA_IN, SCL_IN};
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff[1:0];
      end
   end
   wire scl      = sync2_ff[0];
   wire sda      = sync2_ff[1];
   wire sup_ok   = sync2_ff[2];
   wire osc_ok   = sync2_ff[3];
   wire scl_rise = scl & ~prev_ff[0];
   wire scl_fall = ~scl & prev_ff[0];
   wire start_c  = scl & prev_ff[0] & ~sda & prev_ff[1];
   wire stop_c   = scl & prev_ff[0] & sda & ~prev_ff[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Power-fail lockout with recovery delay

   reg [31:0] rec_cnt_ff;
   reg        access_ok_ff;
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rec_cnt_ff   <= 32'h0;
         access_ok_ff <= 1'b0;
      end else if (!sup_ok) begin
         rec_cnt_ff   <= 32'h0;
         access_ok_ff <= 1'b0;
      end else if (!access_ok_ff) begin
         rec_cnt_ff   <= rec_cnt_ff + 32'h1;
         access_ok_ff <= (rec_cnt_ff >= REC_CYC - 1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   reg [7:0] tr_ff [0:6];   // Running time
   reg [7:0] buf_ff [0:6];  // Read snapshot
   reg [7:0] ctrl_ff;
   reg [7:0] chg_ff;
   reg       osf_ff;
   reg [3:0] ptr_ff;
   reg [31:0] div_ff;
   reg [31:0] ft_ff;
   reg        osc_prev_ff;

   // Slave engine state
   reg [3:0] st_ff;
   reg [7:0] sh_ff;
   reg [3:0] bit_ff;
   reg       rd_ff;
   reg       first_ff;   // Next written byte loads the pointer
   reg       idb_ff;     // Current byte is identification

   wire running = ~tr_ff[0][`ICC_BIT_HALT] & osc_ok;
   wire tick    = running && (div_ff >= SEC_CYC - 1);

   // Write commit strobe at ack drive time
   wire wr_commit = (st_ff == ST_RX) && scl_fall && (bit_ff == 4'h7) &&
                    !idb_ff && !first_ff && !rd_ff && access_ok_ff;
   // All eight bits are already shifted in by the eighth falling edge
   wire [7:0] wbyte = sh_ff;
   // Pointer advance shared by reads and writes
   wire [3:0] ptr_next = (ptr_ff == `ICC_ADDR_CTRL || ptr_ff >= `ICC_ADDR_FLAG) ? 4'h0
                         : ptr_ff + 4'h1;
   wire adv = wr_commit || ((st_ff == ST_ACK) && scl_fall && rd_ff && !idb_ff);
   wire snap = start_c || stop_c || (adv && ptr_next == 4'h0);

   // Second divider; reset by seconds writes
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         div_ff <= 32'h0;
      end else if ((wr_commit && ptr_ff == `ICC_ADDR_SEC) || tick) begin
         div_ff <= 32'h0;
      end else if (running) begin
         div_ff <= div_ff + 32'h1;
      end
   end

   // Calendar counting and register writes
   always @(posedge SYS_CLK or negedge RESETN) begin : cal_p
      reg       c_min, c_hr, c_day, c_mon, c_yr;
      reg [7:0] t_hr;
      if (!RESETN) begin
         tr_ff[0] <= `ICC_RST_SEC;
         tr_ff[1] <= `ICC_RST_MIN;
         tr_ff[2] <= `ICC_RST_HOUR;
         tr_ff[3] <= `ICC_RST_WDAY;
         tr_ff[4] <= `ICC_RST_MDAY;
         tr_ff[5] <= `ICC_RST_MON;
         tr_ff[6] <= `ICC_RST_YEAR;
         ctrl_ff  <= `ICC_RST_CTRL;
         chg_ff   <= `ICC_RST_CHG;
      end else if (wr_commit) begin
         if (ptr_ff <= `ICC_ADDR_YEAR) begin
            tr_ff[ptr_ff[2:0]] <= wbyte;
         end else if (ptr_ff == `ICC_ADDR_CTRL) begin
            ctrl_ff <= wbyte;
         end else if (ptr_ff == `ICC_ADDR_CHG) begin
            chg_ff <= wbyte;
         end
      end else if (tick) begin
         c_min = (tr_ff[0][6:0] == 7'h59);
         tr_ff[0] <= bcd_inc({1'b0, tr_ff[0][6:0]}, 8'h59, 8'h00); // Halt is clear here
         c_hr = c_min && (tr_ff[1][6:0] == 7'h59);
         if (c_min) tr_ff[1] <= bcd_inc({1'b0, tr_ff[1][6:0]}, 8'h59, 8'h00);
         c_day = c_hr && (tr_ff[2][5:0] == 6'h23);
         t_hr = bcd_inc({2'b0, tr_ff[2][5:0]}, 8'h23, 8'h00);
         if (c_hr) tr_ff[2][5:0] <= t_hr[5:0];
         if (c_day) tr_ff[3] <= bcd_inc({5'b0, tr_ff[3][2:0]}, 8'h07, 8'h01);
         c_mon = c_day && ({2'b0, tr_ff[4][5:0]} == month_last(tr_ff[5], tr_ff[6]));
         if (c_day) tr_ff[4] <= c_mon ? 8'h01 : bcd_inc({2'b0, tr_ff[4][5:0]}, 8'h31, 8'h01);
         c_yr = c_mon && (tr_ff[5][4:0] == 5'h12);
         if (c_mon) tr_ff[5] <= bcd_inc({3'b0, tr_ff[5][4:0]}, 8'h12, 8'h01);
         if (c_yr) begin
            tr_ff[6] <= bcd_inc(tr_ff[6], 8'h99, 8'h00);
            if (tr_ff[6] == 8'h99 && tr_ff[2][`ICC_BIT_CEN])
               tr_ff[2][`ICC_BIT_CFLAG] <= ~tr_ff[2][`ICC_BIT_CFLAG];
         end
      end
   end

   // Snapshot buffers
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi = gi + 1) begin : g_buf
         always @(posedge SYS_CLK or negedge RESETN) begin
            if (!RESETN) begin
               buf_ff[gi] <= 8'h00;
            end else if (snap) begin
               buf_ff[gi] <= tr_ff[gi];
            end
         end
      end
   endgenerate

   // Oscillator stop flag; the set wins over a clearing write
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         osf_ff      <= 1'b1;
         osc_prev_ff <= 1'b0;
      end else begin
         osc_prev_ff <= running;
         if (osc_prev_ff && !running) begin
            osf_ff <= 1'b1;
         end else if (wr_commit && ptr_ff == `ICC_ADDR_FLAG && !wbyte[`ICC_BIT_OSF]) begin
            osf_ff <= 1'b0;
         end
      end
   end

   // Read data multiplexer
   reg [7:0] rdata;
   always @* begin
      if (ptr_ff <= `ICC_ADDR_YEAR) begin
         rdata = buf_ff[ptr_ff[2:0]];
      end else if (ptr_ff == `ICC_ADDR_CTRL) begin
         rdata = ctrl_ff;
      end else if (ptr_ff == `ICC_ADDR_CHG) begin
         rdata = chg_ff;
      end else if (ptr_ff == `ICC_ADDR_FLAG) begin
         rdata = {osf_ff, 7'h00};
      end else begin
         rdata = 8'h00;
      end
   end

   // Next read byte after master ack; a wrap snapshots on this edge, so 00h reads live
   reg [7:0] rdata_next;
   always @* begin
      if (ptr_next <= `ICC_ADDR_YEAR) begin
         rdata_next = (ptr_next == 4'h0) ? tr_ff[0] : buf_ff[ptr_next[2:0]];
      end else if (ptr_next == `ICC_ADDR_CTRL) begin
         rdata_next = ctrl_ff;
      end else if (ptr_next == `ICC_ADDR_CHG) begin
         rdata_next = chg_ff;
      end else if (ptr_next == `ICC_ADDR_FLAG) begin
         rdata_next = {osf_ff, 7'h00};
      end else begin
         rdata_next = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // I2C slave engine; SDA changes only after SCL falls

   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_ff    <= ST_IDLE;
         sh_ff    <= 8'h00;
         bit_ff   <= 4'h0;
         rd_ff    <= 1'b0;
         first_ff <= 1'b0;
         idb_ff   <= 1'b0;
         ptr_ff   <= 4'h0;
         SDA_OUT  <= 1'b0;
         SDA_OE   <= 1'b0;
      end else if (stop_c || !access_ok_ff) begin
         st_ff  <= ST_IDLE;
         SDA_OE <= 1'b0;
      end else if (start_c) begin
         st_ff  <= ST_RX;
         // The clock fall that closes START is not a data bit
         bit_ff <= 4'hf;
         idb_ff <= 1'b1;
         SDA_OE <= 1'b0;
      end else begin
         case (st_ff)
            ST_IDLE: begin
               SDA_OE <= 1'b0;
            end
            ST_RX: begin
               if (scl_rise) sh_ff <= {sh_ff[6:0], sda};
               if (scl_fall && bit_ff == 4'h7) begin
                  if (idb_ff) begin
                     if (sh_ff[7:1] == `ICC_DEV_ID) begin
                        rd_ff    <= sh_ff[0];
                        first_ff <= ~sh_ff[0];
                        st_ff    <= ST_ACK;
                        SDA_OE   <= 1'b1;
                     end else begin
                        st_ff <= ST_IDLE;
                     end
                  end else begin
                     if (first_ff) ptr_ff <= sh_ff[3:0];
                     else ptr_ff <= ptr_next;
                     first_ff <= 1'b0;
                     st_ff    <= ST_ACK;
                     SDA_OE   <= 1'b1;
                  end
               end else if (scl_fall) begin
                  bit_ff <= bit_ff + 4'h1;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  bit_ff <= 4'h0;
                  if (rd_ff && !idb_ff) begin
                     ptr_ff <= ptr_next;
                     st_ff  <= ST_TX;
                     SDA_OE <= ~rdata_next[7];
                     sh_ff  <= {rdata_next[6:0], 1'b0};
                  end else if (rd_ff) begin
                     st_ff  <= ST_TX;
                     SDA_OE <= ~rdata[7];
                     sh_ff  <= {rdata[6:0], 1'b0};
                  end else begin
                     st_ff  <= ST_RX;
                     SDA_OE <= 1'b0;
                  end
                  idb_ff <= 1'b0;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_ff == 4'h7) begin
                     SDA_OE <= 1'b0;
                     bit_ff <= 4'h8;
                  end else if (bit_ff == 4'h8) begin
                     st_ff <= ST_IDLE;
                  end else begin
                     SDA_OE <= ~sh_ff[7];
                     sh_ff  <= {sh_ff[6:0], 1'b0};
                     bit_ff <= bit_ff + 4'h1;
                  end
               end else if (scl_rise && bit_ff == 4'h8) begin
                  st_ff <= sda ? ST_IDLE : ST_ACK;
               end
            end
            default: begin
               st_ff <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Test output and charger decode

   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ft_ff      <= 32'h0;
         TEST_OUT   <= 1'b0;
         TEST_OE    <= 1'b0;
         CHARGER_EN <= 1'b0;
         CHARGER_DIODE <= 2'h0;
         CHARGER_RES   <= 2'h0;
      end else begin
         if (ctrl_ff[`ICC_BIT_FTEST]) begin
            ft_ff <= (ft_ff >= `ICC_FT_CYC - 1) ? 32'h0 : ft_ff + 32'h1;
            if (ft_ff >= `ICC_FT_CYC - 1) TEST_OE <= ~TEST_OE;
         end else begin
            ft_ff   <= 32'h0;
            TEST_OE <= ~ctrl_ff[`ICC_BIT_LEVEL];
         end
         CHARGER_EN <= (chg_ff[7:4] == `ICC_CHG_KEY) &&
                       (chg_ff[3:2] == 2'b01 || chg_ff[3:2] == 2'b10) &&
                       (chg_ff[1:0] != 2'b00);
         CHARGER_DIODE <= chg_ff[3:2];
         CHARGER_RES   <= chg_ff[1:0];
      end
   end

endmodule // icc_clock

// ===== logic/icc_regs.vh
// Register map, field positions, reset values and timing counts of the calendar clock
`ifndef ICC_REGS_VH
`define ICC_REGS_VH
`define ICC_ADDR_SEC      4'h0
`define ICC_ADDR_MIN      4'h1
`define ICC_ADDR_HOUR     4'h2
`define ICC_ADDR_WDAY     4'h3
`define ICC_ADDR_MDAY     4'h4
`define ICC_ADDR_MON      4'h5
`define ICC_ADDR_YEAR     4'h6
`define ICC_ADDR_CTRL     4'h7
`define ICC_ADDR_CHG      4'h8
`define ICC_ADDR_FLAG     4'h9
`define ICC_BIT_HALT      7
`define ICC_BIT_CEN       7
`define ICC_BIT_CFLAG     6
`define ICC_BIT_LEVEL     7
`define ICC_BIT_FTEST     6
`define ICC_BIT_OSF       7
`define ICC_RST_SEC       8'h00
`define ICC_RST_MIN       8'h00
`define ICC_RST_HOUR      8'h00
`define ICC_RST_WDAY      8'h01
`define ICC_RST_MDAY      8'h01
`define ICC_RST_MON       8'h01
`define ICC_RST_YEAR      8'h00
`define ICC_RST_CTRL      8'h80
`define ICC_RST_CHG       8'h00
`define ICC_RST_FLAG      8'h80
`define ICC_CHG_KEY       4'ha
`define ICC_DEV_ID        7'h55 // Arbitrary value
`define ICC_CLK_HZ        200000000
`define ICC_SEC_HZ        1
`define ICC_FT_HZ         1024
`define ICC_REC_US        1000
`define ICC_SEC_CYC       (`ICC_CLK_HZ / `ICC_SEC_HZ)
`define ICC_FT_CYC        (`ICC_CLK_HZ / `ICC_FT_HZ)
`define ICC_REC_CYC       ((`ICC_CLK_HZ / 1000000) * `ICC_REC_US)
`endif

// ===== verification/icc_clock_asserts.sv
// Concurrent checks on the calendar clock ports
module icc_clock_asserts #(
   parameter int SEC_CYC = 200,
   parameter int REC_CYC = 20
) (
   input wire logic       SYS_CLK,
   input wire logic       RESETN,
   input wire logic       SCL_IN,
   input wire logic       SDA_IN,
   input wire logic       SDA_OUT,
   input wire logic       SDA_OE,
   input wire logic       SUPPLY_OK,
   input wire logic       OSC_RUNNING,
   input wire logic       TEST_OUT,
   input wire logic       TEST_OE,
   input wire logic       CHARGER_EN,
   input wire logic [1:0] CHARGER_DIODE,
   input wire logic [1:0] CHARGER_RES
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESETN);
   int unsigned ok_cnt_ff;
   int unsigned nxt_ok_cnt;
   ////////////////////////////////////////
   // Age of good supply; counts raw input so it runs ahead of the synchronised copy
   assign nxt_ok_cnt = !SUPPLY_OK ? 0 : ((ok_cnt_ff < REC_CYC) ? ok_cnt_ff + 1 : ok_cnt_ff);
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ok_cnt_ff <= 0;
      end else begin
         ok_cnt_ff <= nxt_ok_cnt;
      end
   end
   ////////////////////////////////////////
   // Ack or data pull is held for at least eight system clocks after it is applied
   sequence s_drive_held;
      SDA_OE [*8];
   endsequence
   // Data line left alone for eight system clocks after the clock rises
   sequence s_oe_quiet;
      $stable(SDA_OE) [*8];
   endsequence
   a_sda_open_drain: assert property (SDA_OUT == 1'b0)
      else $error("SDA driven high");
   a_test_open_drain: assert property (TEST_OUT == 1'b0)
      else $error("test pin driven high");
   a_unpowered_quiet: assert property (!SUPPLY_OK [*5] |-> !SDA_OE)
      else $error("bus answered below trip level");
   a_recover_wait: assert property (SDA_OE |-> ok_cnt_ff >= REC_CYC)
      else $error("bus answered inside recovery delay");
   a_charger_valid: assert property (CHARGER_EN |->
      (CHARGER_DIODE == 2'b01 || CHARGER_DIODE == 2'b10) && CHARGER_RES != 2'b00)
      else $error("charger on with disabling code");
   a_reset_quiet: assert property ($rose(RESETN) |-> !SDA_OE && !TEST_OE && !CHARGER_EN)
      else $error("outputs not at power-up state");
   a_ack_held: assert property ($rose(SDA_OE) |-> s_drive_held)
      else $error("SDA pull released too early");
   a_scl_high_quiet: assert property ($rose(SCL_IN) |-> s_oe_quiet)
      else $error("SDA changed while SCL high");
   a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
      else $error("SDA pull changed with SCL high");
endmodule // icc_clock_asserts

// ===== verification/icc_i2c_master.sv
// I2C bus master model driving the calendar clock serial port
`include "icc_regs.vh"
module icc_i2c_master (
   output logic scl,
   output logic sda_low,
   input  wire  sda
);
   timeunit 1ns;
   timeprecision 10ps;
   localparam real Q = 31.25; // Quarter of the 125 ns link period
   logic [7:0] buf_q [10];
   // Idle bus: clock stands high, data released to its pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   ////////////////////////////////////////
   // One bit: data set with clock low, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
      #Q;
   endtask
   // start framing, offset so edges miss the system clock
   task automatic start_c;
      #1.1 sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic stop_c;
      sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #(2 * Q);
   endtask
   task automatic byte_w(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // Master acks every byte but the last, which is refused
   task automatic byte_r(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
   // pointer first, then data bytes back to back
   task automatic xfer_w(input logic [3:0] ptr, input int n, output logic ok);
      logic a;
      start_c();
      byte_w({`ICC_DEV_ID, 1'b0}, ok);
      byte_w({4'h0, ptr}, a);
      for (int i = 0; i < n; i++) byte_w(buf_q[i], a);
      stop_c();
   endtask
   // pointer load, repeated start, then reads
   task automatic xfer_r(input logic [3:0] ptr, input int n, output logic ok);
      logic a;
      start_c();
      byte_w({`ICC_DEV_ID, 1'b0}, ok);
      byte_w({4'h0, ptr}, a);
      start_c();
      byte_w({`ICC_DEV_ID, 1'b1}, a);
      for (int i = 0; i < n; i++) byte_r(i == n - 1, buf_q[i]);
      stop_c();
   endtask
endmodule // icc_i2c_master

// ===== verification/icc_clock_tb_top.sv
// Self-checking bench for the I2C calendar clock
`include "icc_regs.vh"
module icc_clock_tb_top;
   timeunit 1ns;
   timeprecision 10ps;
   localparam int SEC_T = 6000; // Short second keeps rollover runs brief
   localparam int REC_T = 400;  // Longer than an id byte, so early access is refused
   typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] r;} icc_row_t;
   logic       SYS_CLK, RESETN, SUPPLY_OK, OSC_RUNNING, m_sda_low, ok;
   wire        SCL_IN, SDA_IN, SDA_OUT, SDA_OE, TEST_OUT, TEST_OE, CHARGER_EN;
   wire  [1:0] CHARGER_DIODE, CHARGER_RES;
   int         bad_count = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   logic [7:0] exp_q [10];
   icc_row_t   rows [13] = '{'{4'h8, 8'ha5, 8'ha5}, '{4'h8, 8'haa, 8'haa}, '{4'h8, 8'ha7, 8'ha7},
      '{4'h8, 8'haf, 8'haf}, '{4'h8, 8'ha0, 8'ha0}, '{4'h8, 8'ha4, 8'ha4}, '{4'h8, 8'h5b, 8'h5b},
      '{4'h7, 8'h3f, 8'h3f}, '{4'h7, 8'h80, 8'h80}, '{4'h1, 8'h45, 8'h45}, '{4'h5, 8'h12, 8'h12},
      '{4'h9, 8'h00, 8'h00}, '{4'h9, 8'hff, 8'h00}};
   // Rollover rows: time written, then time one second later
   logic [7:0] roll_in [4][7] = '{'{8'h59, 8'h59, 8'ha3, 8'h07, 8'h31, 8'h12, 8'h99},
      '{8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h03},
      '{8'h59, 8'h59, 8'h23, 8'h05, 8'h28, 8'h02, 8'h04},
      '{8'h59, 8'h59, 8'h63, 8'h02, 8'h31, 8'h12, 8'h99}};
   logic [7:0] roll_exp [4][7] = '{'{8'h00, 8'h00, 8'hc0, 8'h01, 8'h01, 8'h01, 8'h00},
      '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h03, 8'h03},
      '{8'h00, 8'h00, 8'h00, 8'h06, 8'h29, 8'h02, 8'h04},
      '{8'h00, 8'h00, 8'h40, 8'h03, 8'h01, 8'h01, 8'h00}};
   // Open-drain data line with pull-up
   assign SDA_IN = !(m_sda_low || SDA_OE);
   icc_clock #(.SEC_CYC(SEC_T), .REC_CYC(REC_T)) u_dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
      .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
      .SUPPLY_OK(SUPPLY_OK), .OSC_RUNNING(OSC_RUNNING), .TEST_OUT(TEST_OUT), .TEST_OE(TEST_OE),
      .CHARGER_EN(CHARGER_EN), .CHARGER_DIODE(CHARGER_DIODE), .CHARGER_RES(CHARGER_RES));
   icc_i2c_master u_mst (.scl(SCL_IN), .sda_low(m_sda_low), .sda(SDA_IN));
   ////////////////////////////////////////
   // 200 MHz system clock
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   task automatic end_of_test;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard, well above the expected run length
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 99000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Each transfer starts on a clock edge so link edges never meet a sampling edge
   task automatic rd_cmp(input logic [3:0] ptr, input int n);
      @(posedge SYS_CLK);
      u_mst.xfer_r(ptr, n, ok);
      chk("read ack", 8'h01, {7'h0, ok});
      for (int i = 0; i < n; i++) chk("read data", exp_q[i], u_mst.buf_q[i]);
   endtask
   task automatic wr1(input logic [3:0] ptr, input logic [7:0] d);
      @(posedge SYS_CLK);
      u_mst.buf_q[0] = d;
      u_mst.xfer_w(ptr, 1, ok);
      chk("write ack", 8'h01, {7'h0, ok});
   endtask
   // Charger on only for the key with usable diode and resistor codes
   function automatic logic chg_exp(input logic [7:0] v);
      return v[7:4] == `ICC_CHG_KEY && (v[3:2] == 2'b01 || v[3:2] == 2'b10) && v[1:0] != 2'b00;
   endfunction
   ////////////////////////////////////////
   // Main sequence
   initial begin
      RESETN = 1'b0;
      SUPPLY_OK = 1'b1;
      OSC_RUNNING = 1'b1;
      repeat (20) @(posedge SYS_CLK);
      RESETN <= 1'b1;
      repeat (REC_T + 100) @(posedge SYS_CLK);
      exp_q = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00};
      rd_cmp(4'h0, 9);
      exp_q[0] = 8'h00;
      exp_q[1] = 8'h80;
      exp_q[2] = 8'h00;
      rd_cmp(4'h8, 3);
      foreach (rows[k]) begin
         wr1(rows[k].a, rows[k].w);
         exp_q[0] = rows[k].r;
         rd_cmp(rows[k].a, 1);
         if (rows[k].a == 4'h8) begin
            chk("charger en", {7'h0, chg_exp(rows[k].w)}, {7'h0, CHARGER_EN});
            chk("charger pick", {4'h0, rows[k].w[3:0]}, {4'h0, CHARGER_DIODE, CHARGER_RES});
         end
         if (rows[k].a == 4'h7) chk("test pin", {7'h0, ~rows[k].w[7]}, {7'h0, TEST_OE});
      end
      // Midnight rollovers, each starting from a fresh seconds write
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 7; i++) u_mst.buf_q[i] = roll_in[k][i];
         u_mst.xfer_w(4'h0, 7, ok);
         repeat (4800) @(posedge SYS_CLK);
         for (int i = 0; i < 7; i++) exp_q[i] = roll_exp[k][i];
         rd_cmp(4'h0, 7);
      end
      // Halt bit freezes seconds and raises the stop flag
      wr1(4'h9, 8'h00);
      wr1(4'h0, 8'h80);
      repeat (SEC_T + 200) @(posedge SYS_CLK);
      exp_q[0] = 8'h80;
      rd_cmp(4'h0, 1);
      rd_cmp(4'h9, 1);
      wr1(4'h0, 8'h00);
      wr1(4'h9, 8'h00);
      @(posedge SYS_CLK);
      OSC_RUNNING <= 1'b0;
      repeat (20) @(posedge SYS_CLK);
      OSC_RUNNING <= 1'b1;
      rd_cmp(4'h9, 1);
      // Supply loss, then access inside and after the recovery delay
      @(posedge SYS_CLK);
      SUPPLY_OK <= 1'b0;
      repeat (10) @(posedge SYS_CLK);
      u_mst.xfer_r(4'h0, 1, ok);
      chk("ack unpowered", 8'h00, {7'h0, ok});
      @(posedge SYS_CLK);
      SUPPLY_OK <= 1'b1;
      u_mst.xfer_r(4'h0, 1, ok);
      chk("ack recovering", 8'h00, {7'h0, ok});
      repeat (REC_T) @(posedge SYS_CLK);
      u_mst.start_c();
      u_mst.byte_w({~`ICC_DEV_ID, 1'b0}, ok);
      u_mst.stop_c();
      chk("ack foreign id", 8'h00, {7'h0, ok});
      rd_cmp(4'h9, 1);
      end_of_test();
   end
endmodule // icc_clock_tb_top

bind icc_clock icc_clock_asserts #(.SEC_CYC(SEC_CYC), .REC_CYC(REC_CYC)) u_chk (
   .SYS_CLK(SYS_CLK), .RESETN(RESETN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
   .SDA_OE(SDA_OE), .SUPPLY_OK(SUPPLY_OK), .OSC_RUNNING(OSC_RUNNING), .TEST_OUT(TEST_OUT),
   .TEST_OE(TEST_OE), .CHARGER_EN(CHARGER_EN), .CHARGER_DIODE(CHARGER_DIODE),
   .CHARGER_RES(CHARGER_RES));
